// *** verilog/cgo_pkg.sv ***
// Constants, register map and types for the column gain/offset fix stage
package cgo_pkg;
   localparam int PIX_W     = 16;
   localparam int COEF_W    = 16;
   localparam int COLS      = 64;
   localparam int COL_W     = 6;
   localparam int LEVELS    = 4;
   localparam int LVL_W     = 2;
   localparam int GAIN_FRAC = 12;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int STEP_LSBS = 5;
   localparam int IRQ_W     = 3;

   localparam logic [COEF_W-1:0] GAIN_UNITY  = 16'h1000;
   localparam logic [COEF_W-1:0] OFFSET_ZERO = 16'h0000;
   localparam logic [COEF_W-1:0] OFFSET_STEP = 16'h0020;
   localparam logic [COL_W-1:0]  COL_LAST    = 6'h3F;
   localparam logic [PIX_W-1:0]  PIX_MAX     = 16'hFFFF;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] A_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] A_INDEX  = 8'h04;
   localparam logic [ADDR_W-1:0] A_GAIN   = 8'h08;
   localparam logic [ADDR_W-1:0] A_OFFSET = 8'h0C;
   localparam logic [ADDR_W-1:0] A_CMD    = 8'h10;
   localparam logic [ADDR_W-1:0] A_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] A_STEP   = 8'h18;
   localparam logic [ADDR_W-1:0] A_IRQ_ST = 8'h1C;
   localparam logic [ADDR_W-1:0] A_IRQ_MK = 8'h20;

   // Field positions
   localparam int CTRL_EN       = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CMD_RELOAD    = 0;
   localparam int CMD_PERSIST   = 1;
   localparam int STAT_CALIB    = 0;
   localparam int STAT_SAVED    = 1;
   localparam int IRQ_REJECT    = 0;
   localparam int IRQ_REFUSED   = 1;
   localparam int IRQ_TBL_DONE  = 2;

   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   typedef enum logic [1:0] {
      CGO_FACTORY = 2'h0,
      CGO_USER    = 2'h1,
      CGO_CALIB   = 2'h2
   } cgo_mode_t;
endpackage

// *** verilog/cgo_coef_if.sv ***
// Pixel plus its column coefficients, passed from lookup stage to arithmetic stage
`timescale 1ns/1ps
interface cgo_coef_if;
   logic                            valid;
   logic                            sol;
   logic [cgo_pkg::PIX_W-1:0]       pix;
   logic [cgo_pkg::COEF_W-1:0]      gain;
   logic signed [cgo_pkg::COEF_W-1:0] offset;
   modport src (output valid, sol, pix, gain, offset);
   modport dst (input valid, sol, pix, gain, offset);
endinterface

// *** verilog/cgo_mac.sv ***
// Offset-add, gain-multiply arithmetic stage with clamping
`timescale 1ns/1ps
module cgo_mac (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   cgo_coef_if.dst                        ci,
   output logic                           out_valid,
   output logic                           out_sol,
   output logic [cgo_pkg::PIX_W-1:0]      out_pix
);
   logic signed [cgo_pkg::PIX_W+1:0]      sum;
   logic [cgo_pkg::PIX_W-1:0]             sum_cl;
   logic [cgo_pkg::PIX_W+cgo_pkg::COEF_W-1:0] prod;
   logic [cgo_pkg::PIX_W+cgo_pkg::COEF_W-1:0] scaled;
   logic [cgo_pkg::PIX_W-1:0]             res;

   // Add offset then scale by gain; clamp both steps so dark columns never wrap
   always_comb begin
      sum    = $signed({2'b00, ci.pix}) + $signed({{2{ci.offset[cgo_pkg::COEF_W-1]}}, ci.offset});
      if (sum < 0) begin
         sum_cl = '0;
      end else if (sum[cgo_pkg::PIX_W]) begin
         sum_cl = cgo_pkg::PIX_MAX;
      end else begin
         sum_cl = sum[cgo_pkg::PIX_W-1:0];
      end
      prod   = sum_cl * ci.gain;
      scaled = prod >> cgo_pkg::GAIN_FRAC;
      if (|scaled[cgo_pkg::PIX_W+cgo_pkg::COEF_W-1:cgo_pkg::PIX_W]) begin
         res = cgo_pkg::PIX_MAX;
      end else begin
         res = scaled[cgo_pkg::PIX_W-1:0];
      end
   end

   // One result per input cycle, no stall path
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         out_valid <= 1'b0;
         out_sol   <= 1'b0;
         out_pix   <= '0;
      end else begin
         out_valid <= ci.valid;
         out_sol   <= ci.sol;
         out_pix   <= res;
      end
   end
endmodule // cgo_mac

// *** verilog/cgo_fix.sv ***
// Column gain/offset fix top: APB registers, coefficient tables, pixel lookup
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module cgo_fix (
   input  wire logic                          clock,
   input  wire logic                          rstn,
   input  wire logic [cgo_pkg::ADDR_W-1:0]    paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [cgo_pkg::DATA_W-1:0]    pwdata,
   output logic      [cgo_pkg::DATA_W-1:0]    prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          pix_in_valid,
   input  wire logic                          pix_in_sol,
   input  wire logic [cgo_pkg::PIX_W-1:0]     pix_in_data,
   input  wire logic [cgo_pkg::LVL_W-1:0]     camera_gain_level,
   input  wire logic                          fac_load_en,
   input  wire logic [cgo_pkg::LVL_W-1:0]     fac_load_level,
   input  wire logic [cgo_pkg::COL_W-1:0]     fac_load_col,
   input  wire logic [cgo_pkg::COEF_W-1:0]    fac_load_gain,
   input  wire logic [cgo_pkg::COEF_W-1:0]    fac_load_offset,
   output logic                               pix_out_valid,
   output logic                               pix_out_sol,
   output logic      [cgo_pkg::PIX_W-1:0]     pix_out_data,
   output logic                               irq
);
   // Control registers
   cgo_pkg::cgo_mode_t                 mode_r;
   logic                               en_r;
   logic [cgo_pkg::COL_W-1:0]          idx_r;
   logic                               saved_valid_r;
   logic [cgo_pkg::IRQ_W-1:0]          irq_st_r;
   logic [cgo_pkg::IRQ_W-1:0]          irq_mk_r;
   logic [cgo_pkg::IRQ_W-1:0]          irq_set;

   // Coefficient tables
   logic [cgo_pkg::COEF_W-1:0]         usr_gain [cgo_pkg::COLS];
   logic [cgo_pkg::COEF_W-1:0]         usr_off  [cgo_pkg::COLS];
   logic [cgo_pkg::COEF_W-1:0]         sav_gain [cgo_pkg::COLS];
   logic [cgo_pkg::COEF_W-1:0]         sav_off  [cgo_pkg::COLS];
   logic [cgo_pkg::COEF_W-1:0]         fac_gain [cgo_pkg::LEVELS][cgo_pkg::COLS];
   logic [cgo_pkg::COEF_W-1:0]         fac_off  [cgo_pkg::LEVELS][cgo_pkg::COLS];

   // Bus decode
   logic                               acc_first;
   logic                               commit;
   logic                               wr_ok;
   logic                               in_calib;
   logic                               mapped;
   logic                               tbl_reg;
   logic                               bad_ofs;
   logic                               bad_mode;
   logic                               err_nxt;
   logic [cgo_pkg::DATA_W-1:0]         rd_nxt;
   logic                               do_reload;
   logic                               do_persist;
   cgo_pkg::cgo_mode_t                 wr_mode;

   // Pixel path
   logic [cgo_pkg::COL_W-1:0]          col_r;
   logic [cgo_pkg::COL_W-1:0]          cur_col;
   logic                               s1_valid_r;
   logic                               s1_sol_r;
   logic [cgo_pkg::PIX_W-1:0]          s1_pix_r;
   logic [cgo_pkg::COEF_W-1:0]         s1_gain_r;
   logic [cgo_pkg::COEF_W-1:0]         s1_off_r;
   logic [cgo_pkg::COEF_W-1:0]         sel_gain;
   logic [cgo_pkg::COEF_W-1:0]         sel_off;

   cgo_coef_if                         ci ();

   assign in_calib = (mode_r == cgo_pkg::CGO_CALIB);
   assign wr_mode  = cgo_pkg::cgo_mode_t'(pwdata[cgo_pkg::CTRL_MODE_LSB +: 2]);
   // Access phase is two cycles: first edge registers the answer, second commits
   assign acc_first = psel && penable && !pready;
   assign commit    = psel && penable && pready;
   assign wr_ok     = commit && pwrite && !pslverr;

   // Address decode, refusal and read data, all judged in the first access cycle
   always_comb begin
      mapped   = 1'b1;
      tbl_reg  = 1'b0;
      rd_nxt   = '0;
      unique case (paddr)
         cgo_pkg::A_CTRL: begin
            rd_nxt[cgo_pkg::CTRL_EN] = en_r;
            rd_nxt[cgo_pkg::CTRL_MODE_LSB +: 2] = mode_r;
         end
         cgo_pkg::A_INDEX: begin
            tbl_reg = 1'b1;
            rd_nxt[cgo_pkg::COL_W-1:0] = idx_r;
         end
         cgo_pkg::A_GAIN: begin
            tbl_reg = 1'b1;
            rd_nxt[cgo_pkg::COEF_W-1:0] = usr_gain[idx_r];
         end
         cgo_pkg::A_OFFSET: begin
            tbl_reg = 1'b1;
            rd_nxt[cgo_pkg::COEF_W-1:0] = usr_off[idx_r];
         end
         cgo_pkg::A_CMD: begin
            tbl_reg = 1'b1;                                   // Write-only, reads zero
         end
         cgo_pkg::A_STATUS: begin
            rd_nxt[cgo_pkg::STAT_CALIB] = in_calib;
            rd_nxt[cgo_pkg::STAT_SAVED] = saved_valid_r;
         end
         cgo_pkg::A_STEP: begin
            rd_nxt[cgo_pkg::COEF_W-1:0] = cgo_pkg::OFFSET_STEP;
         end
         cgo_pkg::A_IRQ_ST: begin
            rd_nxt[cgo_pkg::IRQ_W-1:0] = irq_st_r;
         end
         cgo_pkg::A_IRQ_MK: begin
            rd_nxt[cgo_pkg::IRQ_W-1:0] = irq_mk_r;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
      bad_ofs  = pwrite && (paddr == cgo_pkg::A_OFFSET) &&
                 (|pwdata[cgo_pkg::STEP_LSBS-1:0]);
      bad_mode = pwrite && (paddr == cgo_pkg::A_CTRL) &&
                 (pwdata[cgo_pkg::CTRL_MODE_LSB +: 2] == 2'h3);
      err_nxt  = !mapped || (tbl_reg && !in_calib) || bad_ofs || bad_mode;
      if (!mapped || (tbl_reg && !in_calib)) begin
         rd_nxt = '0;
      end
   end

   // APB answer registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= acc_first;
         pslverr <= acc_first && err_nxt;
         prdata  <= acc_first ? rd_nxt : '0;
      end
   end

   assign do_reload  = wr_ok && (paddr == cgo_pkg::A_CMD) && pwdata[cgo_pkg::CMD_RELOAD];
   assign do_persist = wr_ok && (paddr == cgo_pkg::A_CMD) && pwdata[cgo_pkg::CMD_PERSIST];

   // Mode and enable; calibration forces the enable low and ignores writes to it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode_r <= cgo_pkg::CGO_FACTORY;
         en_r   <= 1'b1;
      end else if (wr_ok && (paddr == cgo_pkg::A_CTRL)) begin
         mode_r <= wr_mode;
         en_r   <= (wr_mode == cgo_pkg::CGO_CALIB) ? 1'b0 : pwdata[cgo_pkg::CTRL_EN];
      end
   end

   // Column index for table accesses
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         idx_r <= '0;
      end else if (wr_ok && (paddr == cgo_pkg::A_INDEX)) begin
         idx_r <= pwdata[cgo_pkg::COL_W-1:0];
      end
   end

   // User table: entry writes, or whole-table reload from the saved copy, or from reset values if nothing was saved
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < cgo_pkg::COLS; i++) begin
            usr_gain[i] <= cgo_pkg::GAIN_UNITY;
            usr_off[i]  <= cgo_pkg::OFFSET_ZERO;
         end
      end else if (do_reload) begin
         for (int i = 0; i < cgo_pkg::COLS; i++) begin
            usr_gain[i] <= saved_valid_r ? sav_gain[i] : cgo_pkg::GAIN_UNITY;
            usr_off[i]  <= saved_valid_r ? sav_off[i]  : cgo_pkg::OFFSET_ZERO;
         end
      end else if (wr_ok && (paddr == cgo_pkg::A_GAIN)) begin
         usr_gain[idx_r] <= pwdata[cgo_pkg::COEF_W-1:0];
      end else if (wr_ok && (paddr == cgo_pkg::A_OFFSET)) begin
         usr_off[idx_r]  <= pwdata[cgo_pkg::COEF_W-1:0];
      end
   end

   // Saved copy stands in for non-volatile storage; its contents carry no reset
   always_ff @(posedge clock) begin
      if (do_persist) begin
         for (int i = 0; i < cgo_pkg::COLS; i++) begin
            sav_gain[i] <= usr_gain[i];
            sav_off[i]  <= usr_off[i];
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         saved_valid_r <= 1'b0;
      end else if (do_persist) begin
         saved_valid_r <= 1'b1;
      end
   end

   // Factory sets, one per camera gain level, filled by the boot loader port
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int l = 0; l < cgo_pkg::LEVELS; l++) begin
            for (int i = 0; i < cgo_pkg::COLS; i++) begin
               fac_gain[l][i] <= cgo_pkg::GAIN_UNITY;
               fac_off[l][i]  <= cgo_pkg::OFFSET_ZERO;
            end
         end
      end else if (fac_load_en) begin
         fac_gain[fac_load_level][fac_load_col] <= fac_load_gain;
         fac_off[fac_load_level][fac_load_col]  <= fac_load_offset;
      end
   end

   // Interrupt status: set wins over a same-cycle write-one-to-clear
   always_comb begin
      irq_set = '0;
      irq_set[cgo_pkg::IRQ_REJECT]   = commit && pslverr && pwrite && (paddr == cgo_pkg::A_OFFSET)
                                       && in_calib;
      irq_set[cgo_pkg::IRQ_REFUSED]  = commit && pslverr && tbl_reg && !in_calib;
      irq_set[cgo_pkg::IRQ_TBL_DONE] = do_reload || do_persist;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_st_r <= '0;
         irq_mk_r <= cgo_pkg::IRQ_MASK_RST;
         irq      <= 1'b0;
      end else begin
         if (wr_ok && (paddr == cgo_pkg::A_IRQ_ST)) begin
            irq_st_r <= (irq_st_r & ~pwdata[cgo_pkg::IRQ_W-1:0]) | irq_set;
         end else begin
            irq_st_r <= irq_st_r | irq_set;
         end
         if (wr_ok && (paddr == cgo_pkg::A_IRQ_MK)) begin
            irq_mk_r <= pwdata[cgo_pkg::IRQ_W-1:0];
         end
         irq <= |(irq_st_r & irq_mk_r);
      end
   end

   // Column of the incoming pixel; line start restarts at column zero every row
   assign cur_col = pix_in_sol ? '0 : col_r;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         col_r <= '0;
      end else if (pix_in_valid) begin
         col_r <= (cur_col == cgo_pkg::COL_LAST) ? cgo_pkg::COL_LAST :
                  cur_col + 1'b1;                              // Extra pixels reuse last column
      end
   end

   // Coefficient choice; calibration and disabled both give pass-through values
   always_comb begin
      sel_gain = cgo_pkg::GAIN_UNITY;
      sel_off  = cgo_pkg::OFFSET_ZERO;
      if (en_r && (mode_r == cgo_pkg::CGO_FACTORY)) begin
         sel_gain = fac_gain[camera_gain_level][cur_col];
         sel_off  = fac_off[camera_gain_level][cur_col];
      end else if (en_r && (mode_r == cgo_pkg::CGO_USER)) begin
         sel_gain = usr_gain[cur_col];
         sel_off  = usr_off[cur_col];
      end
   end

   // Lookup stage register; takes a pixel every cycle so the stream never stalls
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_valid_r <= 1'b0;
         s1_sol_r   <= 1'b0;
         s1_pix_r   <= '0;
         s1_gain_r  <= cgo_pkg::GAIN_UNITY;
         s1_off_r   <= cgo_pkg::OFFSET_ZERO;
      end else begin
         s1_valid_r <= pix_in_valid;
         s1_sol_r   <= pix_in_valid && pix_in_sol;
         s1_pix_r   <= pix_in_data;
         s1_gain_r  <= sel_gain;
         s1_off_r   <= sel_off;
      end
   end

   assign ci.valid  = s1_valid_r;
   assign ci.sol    = s1_sol_r;
   assign ci.pix    = s1_pix_r;
   assign ci.gain   = s1_gain_r;
   assign ci.offset = s1_off_r;

   // Arithmetic stage drives the pixel outputs from its own registers
   cgo_mac u_cgo_mac (
      .clock     (clock),
      .rstn      (rstn),
      .ci        (ci.dst),
      .out_valid (pix_out_valid),
      .out_sol   (pix_out_sol),
      .out_pix   (pix_out_data)
   );
endmodule // cgo_fix

// *** sim/cgo_fix_checker.sv ***
// Port-level assertions for the column gain/offset fix stage
`timescale 1ns/1ps
module cgo_fix_checker (
   input wire logic                       clock,
   input wire logic                       rstn,
   input wire logic [cgo_pkg::ADDR_W-1:0] paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [cgo_pkg::DATA_W-1:0] pwdata,
   input wire logic [cgo_pkg::DATA_W-1:0] prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       pix_in_valid,
   input wire logic                       pix_in_sol,
   input wire logic                       pix_out_valid,
   input wire logic                       pix_out_sol
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Pixel path: fixed latency, no stall and no invented pixels
   AST_PIX_LAT: assert property (pix_in_valid |-> ##2 pix_out_valid)
      else $error("pixel did not leave two cycles after entry");
   AST_PIX_ONLY: assert property (pix_out_valid |-> $past(pix_in_valid, 2))
      else $error("output pixel without an input pixel");
   AST_SOL_LAT: assert property (pix_in_valid && pix_in_sol |->
      ##2 (pix_out_valid && pix_out_sol))
      else $error("row start marker lost");
   // Register bus: one wait cycle, answer stands one cycle
   AST_APB_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("bus answer not in second access cycle");
   AST_APB_ONE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_ERR_PAIR: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   // Offset writes off the step are refused, and the step reads back as 32
   AST_OFF_STEP: assert property (pready && pwrite && paddr == cgo_pkg::A_OFFSET &&
      pwdata[4:0] != 5'h0 |-> pslverr)
      else $error("offset write off the step accepted");
   AST_STEP_RD: assert property (pready && !pwrite && paddr == cgo_pkg::A_STEP |->
      prdata == 32'h0000_0020)
      else $error("step size read wrong");
   AST_MODE3: assert property (pready && pwrite && paddr == cgo_pkg::A_CTRL &&
      pwdata[2:1] == 2'h3 |-> pslverr)
      else $error("undefined mode accepted");
endmodule // cgo_fix_checker

bind cgo_fix cgo_fix_checker u_cgo_fix_checker (
   .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pix_in_valid(pix_in_valid), .pix_in_sol(pix_in_sol), .pix_out_valid(pix_out_valid),
   .pix_out_sol(pix_out_sol));

// *** sim/cgo_pix_src.sv ***
// Sensor readout model: streams rows of pixels with random stalls
`timescale 1ns/1ps
module cgo_pix_src (
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 go,
   output logic                      busy,
   output logic                      valid,
   output logic                      sol,
   output logic [cgo_pkg::PIX_W-1:0] data
);
   int seed = 53;
   int left;
   // Busy while a row is due; the bench waits for idle before mode changes
   assign busy = (left != 0);
   // Two pixels past the last column exercise the saturating column count
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         left <= 0;
         valid <= 1'b0;
         sol <= 1'b0;
         data <= '0;
      end else if (left == 0 && go) begin
         left <= cgo_pkg::COLS + 2;
      end else if (left != 0 && ($random(seed) & 3) != 0) begin
         valid <= 1'b1;
         sol <= (left == cgo_pkg::COLS + 2);
         data <= 16'($random(seed));
         left <= left - 1;
      end else begin
         valid <= 1'b0;
         sol <= 1'b0;
         data <= ~data; // Idle lines invert the data every idle cycle, so two idle cycles in a row repeat the last pixel
      end
   end
endmodule // cgo_pix_src

// *** sim/tb.sv ***
// Self-checking bench for the column gain/offset fix stage
`timescale 1ns/1ps
module tb;
   logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        go = 1'b0, fac_load_en = 1'b0, en = 1'b1;
   logic        pready, pslverr, irq, busy, pix_in_valid, pix_in_sol, pix_out_valid, pix_out_sol;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [15:0] pix_in_data, pix_out_data, g_v, o_v;
   logic [15:0] fac_load_gain = '0, fac_load_offset = '0;
   logic [15:0] fg [4][64];
   logic [15:0] fo [4][64];
   logic [15:0] ug [64] = '{default: 16'h1000};
   logic [15:0] uo [64] = '{default: 16'h0000};
   logic [15:0] sg [64];
   logic [15:0] so [64];
   logic [5:0]  fac_load_col = '0, col = '0;
   logic [1:0]  camera_gain_level = '0, fac_load_level = '0, mode = '0;
   logic [15:0] expq [$];
   int          seed = 53, n_fail = 0, samples_checked = 0;

   cgo_fix u_cgo_fix (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pix_in_valid(pix_in_valid), .pix_in_sol(pix_in_sol), .pix_in_data(pix_in_data),
      .camera_gain_level(camera_gain_level), .fac_load_en(fac_load_en),
      .fac_load_level(fac_load_level), .fac_load_col(fac_load_col),
      .fac_load_gain(fac_load_gain), .fac_load_offset(fac_load_offset),
      .pix_out_valid(pix_out_valid), .pix_out_sol(pix_out_sol), .pix_out_data(pix_out_data),
      .irq(irq));
   cgo_pix_src u_cgo_pix_src (.clock(clock), .rstn(rstn), .go(go), .busy(busy),
      .valid(pix_in_valid), .sol(pix_in_sol), .data(pix_in_data));

   // 10 MHz clock
   initial begin
      forever #50 clock = ~clock;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; waits for ready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_fail++;
         conclude();
      end else begin
         if (!w) chk(prdata, exp, "read data");
         chk({31'h0, pslverr}, {31'h0, err}, "error flag");
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic put(input int c, input logic [15:0] g, input logic [15:0] o);
      apb(1'b1, cgo_pkg::A_INDEX, 32'(c), '0, 1'b0);
      apb(1'b1, cgo_pkg::A_GAIN, {16'h0, g}, '0, 1'b0);
      apb(1'b1, cgo_pkg::A_OFFSET, {16'h0, o}, '0, 1'b0);
      ug[c] = g;
      uo[c] = o;
   endtask

   task automatic get(input int c);
      apb(1'b1, cgo_pkg::A_INDEX, 32'(c), '0, 1'b0);
      apb(1'b0, cgo_pkg::A_GAIN, '0, {16'h0, ug[c]}, 1'b0);
      apb(1'b0, cgo_pkg::A_OFFSET, '0, {16'h0, uo[c]}, 1'b0);
   endtask

   task automatic fill;
      for (int c = 0; c < 64; c++) begin
         put(c, 16'h0800 + 16'($random(seed) & 32'h0000_0FFF), 16'($random(seed)) & 16'hFFE0);
      end
   endtask

   // Stream one row and let it drain; bounded wait on the source
   task automatic row;
      int n;
      @(posedge clock);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 1000) begin
         n_fail++;
         conclude();
      end
      repeat (4) @(posedge clock);
   endtask

   function automatic logic [15:0] expect_pix(input logic [15:0] p, input logic [5:0] c,
                                              input logic [1:0] lv);
      logic [15:0] g;
      logic [15:0] o;
      longint      s;
      g = 16'h1000;
      o = 16'h0000;
      if (en && mode == 2'h0) begin
         g = fg[lv][c];
         o = fo[lv][c];
      end else if (en && mode == 2'h1) begin
         g = ug[c];
         o = uo[c];
      end
      s = longint'(p) + longint'($signed(o));
      s = (s < 0) ? 0 : ((s > 65535) ? 65535 : s);
      s = (s * longint'(g)) >>> 12;
      return (s > 65535) ? 16'hFFFF : 16'(s);
   endfunction

   // Predict each pixel as it is taken, compare it as it leaves
   always @(posedge clock) begin
      if (pix_out_valid === 1'b1) chk(32'(pix_out_data), 32'(expq.pop_front()), "pix");
      if (pix_in_valid === 1'b1) begin
         col = pix_in_sol ? 6'h0 : ((col == cgo_pkg::COL_LAST) ? col : col + 6'h1);
         expq.push_back(expect_pix(pix_in_data, col, camera_gain_level));
      end
   end

   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      apb(1'b0, cgo_pkg::A_CTRL, '0, 32'h0000_0001, 1'b0);
      apb(1'b0, cgo_pkg::A_STEP, '0, 32'h0000_0020, 1'b0);
      apb(1'b0, 8'h24, '0, '0, 1'b1);
      apb(1'b1, cgo_pkg::A_GAIN, 32'h0000_2000, '0, 1'b1);
      apb(1'b0, cgo_pkg::A_IRQ_ST, '0, 32'h0000_0002, 1'b0);
      chk({31'h0, irq}, '0, "masked irq");
      apb(1'b1, cgo_pkg::A_IRQ_MK, 32'h0000_0007, '0, 1'b0);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0000_0001, "irq raised");
      apb(1'b1, cgo_pkg::A_IRQ_ST, 32'h0000_0007, '0, 1'b0);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, '0, "irq cleared");
      apb(1'b1, cgo_pkg::A_CTRL, 32'h0000_0006, '0, 1'b1);
      apb(1'b0, cgo_pkg::A_CTRL, '0, 32'h0000_0001, 1'b0);
      $display("test reset_and_irq done");
      for (int l = 0; l < 4; l++) begin
         for (int c = 0; c < 64; c++) begin
            g_v = 16'h0800 + 16'($random(seed) & 32'h0000_0FFF);
            o_v = 16'($random(seed));
            fg[l][c] = g_v;
            fo[l][c] = o_v;
            @(posedge clock);
            fac_load_en <= 1'b1;
            fac_load_level <= 2'(l);
            fac_load_col <= 6'(c);
            fac_load_gain <= g_v;
            fac_load_offset <= o_v;
         end
      end
      @(posedge clock);
      fac_load_en <= 1'b0;
      for (int l = 0; l < 4; l++) begin
         camera_gain_level <= 2'(l);
         row();
      end
      $display("test factory done");
      apb(1'b1, cgo_pkg::A_CTRL, 32'h0000_0005, '0, 1'b0);
      mode = 2'h2;
      en = 1'b0;
      apb(1'b0, cgo_pkg::A_CTRL, '0, 32'h0000_0004, 1'b0);
      apb(1'b0, cgo_pkg::A_STATUS, '0, 32'h0000_0001, 1'b0);
      row();
      apb(1'b0, cgo_pkg::A_INDEX, '0, '0, 1'b0);
      apb(1'b0, cgo_pkg::A_GAIN, '0, 32'h0000_1000, 1'b0);
      fill();
      apb(1'b1, cgo_pkg::A_OFFSET, 32'h0000_0021, '0, 1'b1);
      apb(1'b0, cgo_pkg::A_OFFSET, '0, {16'h0, uo[63]}, 1'b0);
      apb(1'b0, cgo_pkg::A_IRQ_ST, '0, 32'h0000_0001, 1'b0);
      row();
      apb(1'b1, cgo_pkg::A_CMD, 32'h0000_0001, '0, 1'b0);
      apb(1'b0, cgo_pkg::A_IRQ_ST, '0, 32'h0000_0005, 1'b0);
      ug = '{default: 16'h1000};
      uo = '{default: 16'h0000};
      get(7);
      fill();
      apb(1'b1, cgo_pkg::A_CMD, 32'h0000_0002, '0, 1'b0);
      sg = ug;
      so = uo;
      apb(1'b0, cgo_pkg::A_STATUS, '0, 32'h0000_0003, 1'b0);
      put(5, 16'h0123, 16'h0040);
      apb(1'b1, cgo_pkg::A_CMD, 32'h0000_0001, '0, 1'b0);
      ug = sg;
      uo = so;
      get(5);
      get(63);
      $display("test calibration done");
      apb(1'b1, cgo_pkg::A_CTRL, 32'h0000_0003, '0, 1'b0);
      mode = 2'h1;
      en = 1'b1;
      for (int l = 0; l < 4; l += 3) begin
         camera_gain_level <= 2'(l);
         row();
      end
      apb(1'b1, cgo_pkg::A_CTRL, 32'h0000_0002, '0, 1'b0);
      en = 1'b0;
      row();
      apb(1'b0, cgo_pkg::A_GAIN, '0, '0, 1'b1);
      $display("test user done");
      chk(expq.size(), 0, "pixels never left");
      conclude();
   end
endmodule // tb
